// ---- src/macs_cmd.sv ----
`timescale 1ns/1ps
module macs_cmd
    import macs_pkg::*;
(
    // Clock and resets
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        soft_reset,
    // System interface write strobes (pin domain)
    input  wire logic        wr_cmd,
    input  wire logic        wr_param,
    input  wire logic [7:0]  wr_data,
    // Panel timing
    input  wire logic        frame_start,
    // Decoded settings
    output logic             page_order_bit,
    output logic             column_order_bit,
    output logic             row_column_exchange_bit,
    output logic             refresh_line_order_bit,
    output logic             color_order_bgr,
    output logic             reserved_bit_two,
    output logic [15:0]      scroll_line,
    output logic             idle_mode,
    output logic             fixed_from_bottom
);
    logic [9:0]  pin_s;
    logic        cmd_s_q;
    logic        par_s_q;
    logic        cmd_s_d;
    logic        par_s_d;
    logic        cmd_pulse;
    logic        par_pulse;
    macs_state_t state_q;
    macs_state_t state_d;
    logic [7:0]  memory_access_control_q;
    logic [7:0]  memory_access_control_d;
    logic [15:0] scroll_start_pointer_q;
    logic [15:0] scroll_start_pointer_d;
    logic [7:0]  scroll_high_q;
    logic [7:0]  scroll_high_d;
    logic [15:0] scroll_live_q;
    logic [15:0] scroll_live_d;
    logic        idle_q;
    logic        idle_d;
    logic [7:0]  wr_byte;
    logic        access_load;
    logic        scroll_load;
    logic        idle_clear;
    logic        idle_set;

    function automatic logic is_cmd(input logic [7:0] data, input logic [7:0] code);
        is_cmd = (data == code);
    endfunction : is_cmd

    macs_sync #(.WIDTH(10)) u_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in ({wr_cmd, wr_param, wr_data}),
        .sync_out (pin_s)
    );

    // Edge detection on the synchronised strobes
    always_comb
    begin
        cmd_s_d = pin_s[9];
        par_s_d = pin_s[8];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cmd_s_q <= 1'b0;
            par_s_q <= 1'b0;
        end
        else
        begin
            cmd_s_q <= cmd_s_d;
            par_s_q <= par_s_d;
        end
    end

    assign cmd_pulse = pin_s[9] & ~cmd_s_q;
    assign par_pulse = pin_s[8] & ~par_s_q;
    assign wr_byte   = pin_s[7:0];

    // Command parser: decides what the next parameter byte is for
    always_comb
    begin
        state_d       = state_q;
        scroll_high_d = scroll_high_q;
        access_load   = 1'b0;
        scroll_load   = 1'b0;
        idle_clear    = 1'b0;
        idle_set      = 1'b0;
        // Accepted in every power and display mode
        if (cmd_pulse)
        begin
            state_d = MACS_IDLE;
            if (is_cmd(wr_byte, CMD_ACCESS_CTRL))
                state_d = MACS_ACCESS_PARAM;
            else if (is_cmd(wr_byte, CMD_SCROLL_START))
                state_d = MACS_SCROLL_HIGH;
            else if (is_cmd(wr_byte, CMD_IDLE_OFF))
                idle_clear = 1'b1;
            else if (is_cmd(wr_byte, CMD_IDLE_ON))
                idle_set = 1'b1;
        end
        else if (par_pulse)
        begin
            unique case (state_q)
                MACS_IDLE:
                    state_d = MACS_IDLE;
                MACS_ACCESS_PARAM:
                begin
                    access_load = 1'b1;
                    state_d     = MACS_IDLE;
                end
                MACS_SCROLL_HIGH:
                begin
                    scroll_high_d = wr_byte;
                    state_d       = MACS_SCROLL_LOW;
                end
                MACS_SCROLL_LOW:
                begin
                    scroll_load = 1'b1;
                    state_d     = MACS_IDLE;
                end
            endcase
        end
        // Software reset wins over a byte arriving in the same cycle
        if (soft_reset)
        begin
            state_d     = MACS_IDLE;
            access_load = 1'b0;
            scroll_load = 1'b0;
            idle_set    = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_q       <= MACS_IDLE;
            scroll_high_q <= 8'h00;
        end
        else
        begin
            state_q       <= state_d;
            scroll_high_q <= scroll_high_d;
        end
    end

    // Access control setting survives a software reset
    always_comb
    begin
        memory_access_control_d = memory_access_control_q;
        if (access_load)
            memory_access_control_d = wr_byte;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            memory_access_control_q <= ACCESS_RESET;
        else
            memory_access_control_q <= memory_access_control_d;
    end

    // Scroll pointer: stored value, and the copy the panel scan uses
    always_comb
    begin
        scroll_start_pointer_d = scroll_start_pointer_q;
        scroll_live_d          = scroll_live_q;
        if (scroll_load)
            scroll_start_pointer_d = {scroll_high_q, wr_byte};
        if (frame_start)
            scroll_live_d = scroll_start_pointer_q;
        if (soft_reset)
        begin
            scroll_start_pointer_d = SCROLL_RESET;
            scroll_live_d          = SCROLL_RESET;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            scroll_start_pointer_q <= SCROLL_RESET;
            scroll_live_q          <= SCROLL_RESET;
        end
        else
        begin
            scroll_start_pointer_q <= scroll_start_pointer_d;
            scroll_live_q          <= scroll_live_d;
        end
    end

    // Idle mode flag
    always_comb
    begin
        idle_d = idle_q;
        if (idle_clear)
            idle_d = 1'b0;
        else if (idle_set)
            idle_d = 1'b1;
        if (soft_reset)
            idle_d = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            idle_q <= 1'b0;
        else
            idle_q <= idle_d;
    end

    assign page_order_bit          = memory_access_control_q[PAGE_ORDER_POS];
    assign column_order_bit        = memory_access_control_q[COLUMN_ORDER_POS];
    assign row_column_exchange_bit = memory_access_control_q[EXCHANGE_POS];
    assign refresh_line_order_bit  = memory_access_control_q[LINE_ORDER_POS];
    assign color_order_bgr         = memory_access_control_q[COLOR_ORDER_POS];
    assign reserved_bit_two        = memory_access_control_q[RESERVED_TWO_POS];
    assign fixed_from_bottom       = memory_access_control_q[LINE_ORDER_POS];
    assign scroll_line             = scroll_live_q;
    assign idle_mode               = idle_q;

    chk_soft_keeps_access: assert property (@(posedge mclk) disable iff (reset)
        soft_reset |=> memory_access_control_q == $past(memory_access_control_q))
        else $error("soft reset changed access control");
    chk_soft_clears_scroll: assert property (@(posedge mclk) disable iff (reset)
        soft_reset |=> scroll_start_pointer_q == SCROLL_RESET && !idle_q)
        else $error("soft reset left scroll or idle");
    chk_idle_off_cmd: assert property (@(posedge mclk) disable iff (reset)
        cmd_pulse && pin_s[7:0] == CMD_IDLE_OFF |=> !idle_mode)
        else $error("idle off not applied");
    chk_idle_off_noop: assert property (@(posedge mclk) disable iff (reset)
        cmd_pulse && pin_s[7:0] == CMD_IDLE_OFF && !idle_q |=> $stable(memory_access_control_q) && !idle_q)
        else $error("idle off had an effect");
    chk_access_load: assert property (@(posedge mclk) disable iff (reset)
        par_pulse && !cmd_pulse && !soft_reset && state_q == MACS_ACCESS_PARAM
        |=> memory_access_control_q == $past(pin_s[7:0]))
        else $error("access parameter not stored");
    chk_scroll_pair: assert property (@(posedge mclk) disable iff (reset)
        par_pulse && !cmd_pulse && !soft_reset && state_q == MACS_SCROLL_LOW
        |=> scroll_start_pointer_q == {$past(scroll_high_q), $past(pin_s[7:0])})
        else $error("scroll pointer wrong");
    chk_scroll_frame: assert property (@(posedge mclk) disable iff (reset)
        !frame_start && !soft_reset |=> $stable(scroll_line))
        else $error("scroll changed mid frame");
    chk_partial_hold: assert property (@(posedge mclk) disable iff (reset)
        state_q == MACS_SCROLL_HIGH && !soft_reset |=> $stable(scroll_start_pointer_q))
        else $error("pointer changed before last byte");
    chk_bits_map: assert property (@(posedge mclk) disable iff (reset)
        access_load |=> page_order_bit == $past(wr_byte[PAGE_ORDER_POS])
        && color_order_bgr == $past(wr_byte[COLOR_ORDER_POS]))
        else $error("bit map wrong");
    chk_column_bits: assert property (@(posedge mclk) disable iff (reset)
        access_load |=> column_order_bit == $past(wr_byte[COLUMN_ORDER_POS])
        && row_column_exchange_bit == $past(wr_byte[EXCHANGE_POS]))
        else $error("column or exchange bit wrong");
    chk_line_bits: assert property (@(posedge mclk) disable iff (reset)
        access_load |=> refresh_line_order_bit == $past(wr_byte[LINE_ORDER_POS])
        && fixed_from_bottom == $past(wr_byte[LINE_ORDER_POS]))
        else $error("line order bit wrong");
    chk_idle_on_cmd: assert property (@(posedge mclk) disable iff (reset)
        cmd_pulse && wr_byte == CMD_IDLE_ON && !soft_reset |=> idle_mode)
        else $error("idle on not applied");
    chk_idle_hold: assert property (@(posedge mclk) disable iff (reset)
        !cmd_pulse && !soft_reset |=> $stable(idle_q))
        else $error("idle changed without a command");
    chk_access_hold: assert property (@(posedge mclk) disable iff (reset)
        !access_load |=> $stable(memory_access_control_q))
        else $error("access control changed without a parameter");
    chk_scroll_live: assert property (@(posedge mclk) disable iff (reset)
        frame_start && !soft_reset |=> scroll_line == $past(scroll_start_pointer_q))
        else $error("scroll pointer not applied at frame start");
    chk_hw_reset_vals: assert property (@(posedge mclk)
        reset |=> memory_access_control_q == ACCESS_RESET && scroll_line == SCROLL_RESET && !idle_mode)
        else $error("hardware reset values wrong");
    cov_access: cover property (@(posedge mclk) state_q == MACS_ACCESS_PARAM ##1 state_q == MACS_IDLE);
    cov_scroll: cover property (@(posedge mclk) state_q == MACS_SCROLL_LOW ##[1:20] frame_start);
    cov_idle:   cover property (@(posedge mclk) idle_q ##1 !idle_q);
    cov_abort:  cover property (@(posedge mclk) state_q == MACS_SCROLL_LOW && cmd_pulse);
    cov_soft:   cover property (@(posedge mclk) soft_reset && idle_q);
endmodule : macs_cmd

// ---- src/macs_pkg.sv ----
package macs_pkg;
    localparam logic [7:0]  CMD_ACCESS_CTRL   = 8'h36;
    localparam logic [7:0]  CMD_SCROLL_START  = 8'h37;
    localparam logic [7:0]  CMD_IDLE_OFF      = 8'h38;
    localparam logic [7:0]  CMD_IDLE_ON       = 8'h39;
    localparam logic [7:0]  ACCESS_RESET      = 8'h00;
    localparam logic [15:0] SCROLL_RESET      = 16'h0000;
    localparam int          PAGE_ORDER_POS    = 7;
    localparam int          COLUMN_ORDER_POS  = 6;
    localparam int          EXCHANGE_POS      = 5;
    localparam int          LINE_ORDER_POS    = 4;
    localparam int          COLOR_ORDER_POS   = 3;
    localparam int          RESERVED_TWO_POS  = 2;
    typedef enum logic [1:0] {
        MACS_IDLE,
        MACS_ACCESS_PARAM,
        MACS_SCROLL_HIGH,
        MACS_SCROLL_LOW
    } macs_state_t;
endpackage : macs_pkg

// ---- src/macs_sync.sv ----
`timescale 1ns/1ps
module macs_sync
    import macs_pkg::*;
#(
    parameter int WIDTH = 1
)(
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : macs_sync

// ---- sim/macs_host.sv ----
`timescale 1ns/1ps
module macs_host (
    // Clock
    input  wire logic       mclk,
    // Write strobes and data toward the device
    output logic            wr_cmd,
    output logic            wr_param,
    output logic [7:0]      wr_data
);
    initial
    begin
        wr_cmd   = 1'h0;
        wr_param = 1'h0;
        wr_data  = 8'hFF;
    end

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // Data settles 3 cycles before the strobe and holds 3 after it drops
    task automatic put(input logic is_param, input logic [7:0] b);
        step(1);
        wr_data  = b;
        step(3);
        wr_cmd   = !is_param;
        wr_param = is_param;
        step(4);
        wr_cmd   = 1'h0;
        wr_param = 1'h0;
        step(3);
        wr_data  = ~b;
    endtask : put
endmodule : macs_host

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb
    import macs_pkg::*;
;
    typedef struct packed {logic [7:0] prm; logic [6:0] exp;} macs_row_t;
    localparam macs_row_t ROWS [8] = '{'{8'h80, 7'h40}, '{8'h40, 7'h20}, '{8'h20, 7'h10},
        '{8'h10, 7'h09}, '{8'h08, 7'h04}, '{8'h04, 7'h02}, '{8'h03, 7'h00}, '{8'hFF, 7'h7F}};
    logic        mclk = 1'h0;
    logic        reset, soft_reset, frame_start, wr_cmd, wr_param;
    logic [7:0]  wr_data;
    logic        pg, col, exch, line, bgr, res, fixb, idle_mode;
    logic [15:0] scroll_line;
    logic [6:0]  bits;
    int          failures = 0;
    int          compares = 0;
    int          cycles   = 0;

    assign bits = {pg, col, exch, line, bgr, res, fixb};
    always #2.5 mclk = ~mclk;

    macs_host h (.mclk(mclk), .wr_cmd(wr_cmd), .wr_param(wr_param), .wr_data(wr_data));
    macs_cmd DUT (.mclk(mclk), .reset(reset), .soft_reset(soft_reset), .wr_cmd(wr_cmd),
        .wr_param(wr_param), .wr_data(wr_data), .frame_start(frame_start), .page_order_bit(pg),
        .column_order_bit(col), .row_column_exchange_bit(exch), .refresh_line_order_bit(line),
        .color_order_bgr(bgr), .reserved_bit_two(res), .scroll_line(scroll_line),
        .idle_mode(idle_mode), .fixed_from_bottom(fixb));

    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic note(input logic ok, input string what);
        compares++;
        if (ok !== 1'h1)
        begin
            failures++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask : note
    task automatic cmp_bits(input logic [6:0] exp);
        note(bits === exp, "access bits");
    endtask : cmp_bits
    task automatic cmp_ptr(input logic [15:0] exp);
        note(scroll_line === exp, "scroll line");
    endtask : cmp_ptr
    task automatic cmp_idle(input logic exp);
        note(idle_mode === exp, "idle mode");
    endtask : cmp_idle

    task automatic frame();
        frame_start = 1'h1;
        h.step(1);
        frame_start = 1'h0;
        h.step(2);
    endtask : frame

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            finish_test();
        end
    end

    initial
    begin
        reset       = 1'h1;
        soft_reset  = 1'h0;
        frame_start = 1'h0;
        h.step(12);
        reset = 1'h0;
        h.step(1);
        cmp_bits(7'h00);
        cmp_ptr(16'h0000);
        cmp_idle(1'h0);
        foreach (ROWS[i])
        begin
            h.put(1'h0, CMD_ACCESS_CTRL);
            h.put(1'h1, ROWS[i].prm);
            cmp_bits(ROWS[i].exp);
        end
        // A parameter with no command pending is dropped
        h.put(1'h0, CMD_IDLE_OFF);
        h.put(1'h1, 8'h00);
        cmp_bits(7'h7F);
        cmp_idle(1'h0);
        h.put(1'h0, CMD_IDLE_ON);
        cmp_idle(1'h1);
        h.put(1'h0, CMD_IDLE_OFF);
        cmp_idle(1'h0);
        h.put(1'h0, CMD_SCROLL_START);
        h.put(1'h1, 8'h01);
        h.put(1'h1, 8'h3C);
        cmp_ptr(16'h0000);
        frame();
        cmp_ptr(16'h013C);
        // High byte alone, then another command: pointer must not move
        h.put(1'h0, CMD_SCROLL_START);
        h.put(1'h1, 8'h00);
        h.put(1'h0, CMD_IDLE_ON);
        frame();
        cmp_ptr(16'h013C);
        cmp_idle(1'h1);
        soft_reset = 1'h1;
        h.step(1);
        soft_reset = 1'h0;
        h.step(2);
        cmp_bits(7'h7F);
        cmp_ptr(16'h0000);
        cmp_idle(1'h0);
        reset = 1'h1;
        h.step(2);
        reset = 1'h0;
        h.step(1);
        cmp_bits(7'h00);
        finish_test();
    end
endmodule : tb
